// ===== testbench/cbx_core_test.sv
`timescale 1ns/1ps
module cbx_core_test;
    import cbx_pkg::*;

    logic        i_clk_sys;
    logic        i_rst;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic [14:0] o_pc;
    logic        o_busy;
    logic [14:0] exp_pc;
    logic [31:0] rd;
    logic        er;
    int          error_cnt;
    int          check_count;

    cbx_core dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_pc(o_pc), .o_busy(o_busy));

    // ==================================================================
    // Shared tasks
    task automatic wrap_up;
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // The answer is taken at the rising edge that completes the transfer, before
    // that edge's own updates land, and the request is released only after it.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        logic rdy;
        @(posedge i_clk_sys);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= wr;
        i_paddr   <= addr;
        i_pwdata  <= wd;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        rdy = 1'b0;
        for (int n = 0; n < 50 && !rdy; n++) begin
            @(posedge i_clk_sys);
            rdy = (o_pready === 1'b1);
            if (rdy) begin
                rd = o_prdata;
                er = o_pslverr;
            end
        end
        check("pready", 32'(rdy), 32'h1);
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [7:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
        check("write error", 32'(er), 32'h0);
    endtask : wr_reg

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(name, rd, exp);
    endtask : rd_chk

    task automatic set_file(input logic [6:0] idx, input logic [7:0] val);
        wr_reg(ADDR_FADDR, 32'(idx));
        wr_reg(ADDR_FDATA, 32'(val));
    endtask : set_file

    task automatic state_chk(input logic [7:0] acc, input logic [7:0] fv, input logic z,
                             input logic c);
        rd_chk("acc", ADDR_ACC, 32'(acc));
        rd_chk("file", ADDR_FDATA, 32'(fv));
        rd_chk("status", ADDR_STATUS, {29'h0, c, z, 1'b0});
    endtask : state_chk

    task automatic exec(input logic [2:0] op, input logic d, input logic [10:0] opnd);
        int cnt;
        int cyc;
        cyc = (op == OP_JUMP) ? 2 * CYC_CLKS : CYC_CLKS;
        if (op != OP_JUMP) exp_pc = exp_pc + 15'h0001;
        wr_reg(ADDR_ISSUE, {17'h0, op, d, opnd});
        cnt = 0;
        @(negedge i_clk_sys);
        while (o_busy === 1'b1 && cnt < 100) begin
            @(negedge i_clk_sys);
            cnt++;
        end
        check("busy cycles", 32'(cnt), 32'(cyc));
        check("pc", 32'(o_pc), 32'(exp_pc));
    endtask : exec

    // ==================================================================
    // Scenarios
    task automatic t_jump;
        wr_reg(ADDR_LATCH, 32'h5A);
        wr_reg(ADDR_STATUS, 32'h6);
        exp_pc = 15'h5FFF;
        exec(OP_JUMP, 1'b0, 11'h7FF);
        rd_chk("status", ADDR_STATUS, 32'h6);
        wr_reg(ADDR_LATCH, 32'h40);
        wr_reg(ADDR_STATUS, 32'h0);
        exp_pc = 15'h4000;
        exec(OP_JUMP, 1'b1, 11'h000);
        rd_chk("status", ADDR_STATUS, 32'h0);
    endtask : t_jump

    task automatic t_or;
        set_file(7'h33, 8'h0F);
        wr_reg(ADDR_ACC, 32'h50);
        wr_reg(ADDR_STATUS, 32'h4);
        exec(OP_ORL, 1'b1, 11'h70A);
        state_chk(8'h5A, 8'h0F, 1'b0, 1'b1);
        wr_reg(ADDR_ACC, 32'h00);
        exec(OP_ORL, 1'b0, 11'h700);
        state_chk(8'h00, 8'h0F, 1'b1, 1'b1);
        wr_reg(ADDR_ACC, 32'hF0);
        exec(OP_ORF, 1'b0, 11'h033);
        state_chk(8'hFF, 8'h0F, 1'b0, 1'b1);
        wr_reg(ADDR_ACC, 32'h30);
        exec(OP_ORF, 1'b1, 11'h033);
        state_chk(8'h30, 8'h3F, 1'b0, 1'b1);
    endtask : t_or

    task automatic t_inc;
        set_file(7'h7F, 8'hFF);
        exec(OP_INC, 1'b1, 11'h07F);
        state_chk(8'h30, 8'h00, 1'b1, 1'b1);
        exec(OP_INC, 1'b0, 11'h07F);
        state_chk(8'h01, 8'h00, 1'b0, 1'b1);
    endtask : t_inc

    task automatic t_shift;
        set_file(7'h10, 8'h81);
        wr_reg(ADDR_STATUS, 32'h0);
        exec(OP_SHL, 1'b1, 11'h010);
        state_chk(8'h01, 8'h02, 1'b0, 1'b1);
        exec(OP_SHR, 1'b0, 11'h010);
        state_chk(8'h01, 8'h02, 1'b0, 1'b0);
        set_file(7'h10, 8'h01);
        exec(OP_SHR, 1'b1, 11'h010);
        state_chk(8'h01, 8'h00, 1'b1, 1'b1);
        exec(OP_SHL, 1'b0, 11'h010);
        state_chk(8'h00, 8'h00, 1'b1, 1'b0);
    endtask : t_shift

    task automatic t_refuse;
        wr_reg(ADDR_ISSUE, {17'h0, OP_INC, 1'b0, 11'h010});
        exp_pc = exp_pc + 15'h0001;
        apb(1'b1, ADDR_ACC, 32'h77);
        check("busy write error", 32'(er), 32'h1);
        repeat (2 * CYC_CLKS) @(posedge i_clk_sys);
        rd_chk("acc", ADDR_ACC, 32'h01);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped error", 32'(er), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, ADDR_ISSUE, 32'h6000);
        check("bad op error", 32'(er), 32'h1);
        repeat (2 * CYC_CLKS) @(posedge i_clk_sys);
        check("pc", 32'(o_pc), 32'(exp_pc));
    endtask : t_refuse

    task automatic t_reset;
        wr_reg(ADDR_PC, 32'h1234);
        rd_chk("pc", ADDR_PC, 32'h1234);
        rd_chk("issue", ADDR_ISSUE, 32'h3010);
        rd_chk("latch", ADDR_LATCH, 32'h40);
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        exp_pc = 15'h0000;
        rd_chk("acc reset", ADDR_ACC, 32'h0);
        rd_chk("latch reset", ADDR_LATCH, 32'h0);
        rd_chk("faddr reset", ADDR_FADDR, 32'h0);
        rd_chk("fdata reset", ADDR_FDATA, 32'h0);
        rd_chk("issue reset", ADDR_ISSUE, 32'h0);
        rd_chk("pc reset", ADDR_PC, 32'h0);
        exec(OP_ORL, 1'b0, 11'h0A5);
        state_chk(8'hA5, 8'h00, 1'b0, 1'b0);
    endtask : t_reset

    // ==================================================================
    // Clock, reset, sequence and watchdog
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        #400000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        i_rst       = 1'b1;
        i_psel      = 1'b0;
        i_penable   = 1'b0;
        i_pwrite    = 1'b0;
        i_paddr     = 8'h00;
        i_pwdata    = 32'h0;
        error_cnt   = 0;
        check_count = 0;
        exp_pc      = 15'h0000;
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd_chk("pc reset", ADDR_PC, 32'h0);
        rd_chk("status reset", ADDR_STATUS, 32'h0);
        t_jump();
        t_or();
        t_inc();
        t_shift();
        t_refuse();
        t_reset();
        wrap_up();
    end
endmodule : cbx_core_test

// ===== verilog/cbx_alu.sv
`timescale 1ns/1ps
module cbx_alu (
    input  wire cbx_pkg::cbx_insn_s i_insn,
    input  wire logic [7:0]         i_acc,
    input  wire logic [7:0]         i_fval,
    input  wire logic               i_carry,
    output cbx_pkg::cbx_alu_s       o_res
);
    import cbx_pkg::*;

    always_comb begin
        o_res           = '0;
        o_res.carry     = i_carry;
        o_res.to_file   = i_insn.dest;
        unique case (i_insn.op)
            OP_ORL: begin
                o_res.value   = i_acc | i_insn.operand[7:0];
                o_res.to_file = 1'b0;
            end
            OP_ORF: o_res.value = i_acc | i_fval;
            OP_INC: o_res.value = i_fval + 8'h01;
            OP_SHL: begin
                o_res.value     = {i_fval[6:0], 1'b0};
                o_res.carry     = i_fval[7];
                o_res.carry_upd = 1'b1;
            end
            OP_SHR: begin
                o_res.value     = {1'b0, i_fval[7:1]};
                o_res.carry     = i_fval[0];
                o_res.carry_upd = 1'b1;
            end
            default: o_res.value = i_acc;
        endcase
        o_res.zero = (o_res.value == 8'h00);
    end

endmodule : cbx_alu

// ===== verilog/cbx_core.sv
`timescale 1ns/1ps
module cbx_core (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic [14:0]      o_pc,
    output logic             o_busy
);
    import cbx_pkg::*;

    // ==================================================================
    // State
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CYC1 = 3'b010,
        ST_CYC2 = 3'b100
    } cbx_state_e;

    cbx_state_e  state_r, state_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    cbx_insn_s   insn_r, insn_nxt;
    logic [7:0]  acc_r, acc_nxt;
    logic        z_r, z_nxt;
    logic        c_r, c_nxt;
    logic [14:0] pc_r, pc_nxt;
    logic [6:0]  latch_r, latch_nxt;
    logic [6:0]  faddr_r, faddr_nxt;
    logic [7:0]  file_r [128];
    logic [7:0]  file_nxt [128];
    logic [31:0] prdata_r, prdata_nxt;

    logic        busy, tick, fire_alu, fire_jmp;
    logic        access, unmapped, bad_op, wr, issue;
    logic [7:0]  fval, dst_val;
    logic [31:0] rd_sel;
    cbx_alu_s    res;

    // ==================================================================
    // Bus decode
    assign busy   = (state_r != ST_IDLE);
    assign access = i_psel && i_penable;
    assign bad_op = (i_pwdata[ISSUE_OP_LSB +: 3] > OP_LAST);

    always_comb begin
        unmapped = 1'b0;
        unique case (i_paddr)
            ADDR_ISSUE, ADDR_STATUS, ADDR_ACC, ADDR_PC,
            ADDR_LATCH, ADDR_FADDR, ADDR_FDATA: unmapped = 1'b0;
            default: unmapped = 1'b1;
        endcase
    end

    // Writes during execution are refused so the datapath never races the bus.
    assign o_pslverr = access && (unmapped || (i_pwrite && busy)
                       || (i_pwrite && i_paddr == ADDR_ISSUE && bad_op));
    assign o_pready  = 1'b1;
    assign wr        = access && i_pwrite && !o_pslverr;
    assign issue     = wr && (i_paddr == ADDR_ISSUE);

    always_comb begin
        rd_sel = 32'h0000_0000;
        unique case (i_paddr)
            ADDR_ISSUE:  rd_sel = {17'h00000, insn_r};
            ADDR_STATUS: rd_sel = {29'h0000_0000, c_r, z_r, busy};
            ADDR_ACC:    rd_sel = {24'h00_0000, acc_r};
            ADDR_PC:     rd_sel = {17'h00000, pc_r};
            ADDR_LATCH:  rd_sel = {25'h000_0000, latch_r};
            ADDR_FADDR:  rd_sel = {25'h000_0000, faddr_r};
            ADDR_FDATA:  rd_sel = {24'h00_0000, file_r[faddr_r]};
            default:     rd_sel = 32'h0000_0000;
        endcase
        // Read data is latched in the setup phase so the answer comes from a flop.
        prdata_nxt = (i_psel && !i_penable) ? rd_sel : prdata_r;
    end

    // ==================================================================
    // Instruction cycle divider and sequencing
    assign tick     = busy && (cnt_r == CYC_LAST);
    assign fire_jmp = (state_r == ST_CYC1) && tick && (insn_r.op == OP_JUMP);
    assign fire_alu = (state_r == ST_CYC1) && tick && (insn_r.op != OP_JUMP);
    assign fval     = file_r[insn_r.operand[6:0]];
    assign dst_val  = (insn_r.dest && insn_r.op != OP_ORL) ? fval : acc_r;

    cbx_alu u_alu (
        .i_insn  (insn_r),
        .i_acc   (acc_r),
        .i_fval  (fval),
        .i_carry (c_r),
        .o_res   (res)
    );

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = busy ? (tick ? 4'h0 : cnt_r + 4'h1) : 4'h0;
        insn_nxt  = insn_r;
        unique case (state_r)
            ST_IDLE: if (issue) begin
                state_nxt = ST_CYC1;
                insn_nxt  = cbx_insn_s'(i_pwdata[14:0]);
            end
            ST_CYC1: if (tick) begin
                state_nxt = (insn_r.op == OP_JUMP) ? ST_CYC2 : ST_IDLE;
            end
            ST_CYC2: if (tick) begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ==================================================================
    // Architectural state
    always_comb begin
        acc_nxt   = acc_r;
        z_nxt     = z_r;
        c_nxt     = c_r;
        pc_nxt    = pc_r;
        latch_nxt = latch_r;
        faddr_nxt = faddr_r;
        file_nxt  = file_r;
        if (wr) begin
            unique case (i_paddr)
                ADDR_STATUS: begin
                    z_nxt = i_pwdata[STAT_ZERO_BIT];
                    c_nxt = i_pwdata[STAT_CARRY_BIT];
                end
                ADDR_ACC:   acc_nxt   = i_pwdata[7:0];
                ADDR_PC:    pc_nxt    = i_pwdata[14:0];
                ADDR_LATCH: latch_nxt = i_pwdata[6:0];
                ADDR_FADDR: faddr_nxt = i_pwdata[6:0];
                ADDR_FDATA: file_nxt[faddr_r] = i_pwdata[7:0];
                default: ;
            endcase
        end
        if (fire_jmp) begin
            pc_nxt = {latch_r[JMP_LATCH_HI:JMP_LATCH_LO], insn_r.operand};
        end
        if (fire_alu) begin
            pc_nxt = pc_r + 15'h0001;
            z_nxt  = res.zero;
            if (res.carry_upd) begin
                c_nxt = res.carry;
            end
            if (res.to_file) begin
                file_nxt[insn_r.operand[6:0]] = res.value;
            end else begin
                acc_nxt = res.value;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_r  <= ST_IDLE;
            cnt_r    <= 4'h0;
            insn_r   <= '0;
            acc_r    <= ACC_RST;
            z_r      <= FLAG_RST;
            c_r      <= FLAG_RST;
            pc_r     <= PC_RST;
            latch_r  <= LATCH_RST;
            faddr_r  <= FADDR_RST;
            prdata_r <= 32'h0000_0000;
            for (int i = 0; i < 128; i++) begin
                file_r[i] <= FILE_RST;
            end
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            insn_r   <= insn_nxt;
            acc_r    <= acc_nxt;
            z_r      <= z_nxt;
            c_r      <= c_nxt;
            pc_r     <= pc_nxt;
            latch_r  <= latch_nxt;
            faddr_r  <= faddr_nxt;
            prdata_r <= prdata_nxt;
            file_r   <= file_nxt;
        end
    end

    assign o_prdata = prdata_r;
    assign o_pc     = pc_r;
    assign o_busy   = busy;

    // ==================================================================
    // Checks
    property p_jump_low;
        @(posedge i_clk_sys) disable iff (i_rst)
        fire_jmp |=> pc_r[10:0] == $past(insn_r.operand);
    endproperty
    a_jump_low: assert property (p_jump_low)
        else $error("Jump did not load the literal into the low counter bits.");

    property p_jump_high;
        @(posedge i_clk_sys) disable iff (i_rst)
        fire_jmp |=> pc_r[14:11] == $past(latch_r[6:3]);
    endproperty
    a_jump_high: assert property (p_jump_high)
        else $error("Jump did not fill the high counter bits from the latch.");

    property p_jump_time;
        @(posedge i_clk_sys) disable iff (i_rst)
        (issue && i_pwdata[14:12] == OP_JUMP) |-> ##20 busy ##1 !busy;
    endproperty
    a_jump_time: assert property (p_jump_time)
        else $error("Jump did not take exactly two instruction cycles.");

    property p_jump_flags;
        @(posedge i_clk_sys) disable iff (i_rst)
        (busy && insn_r.op == OP_JUMP) |=> $stable(z_r) && $stable(c_r);
    endproperty
    a_jump_flags: assert property (p_jump_flags)
        else $error("Jump changed a status flag.");

    property p_or_lit;
        @(posedge i_clk_sys) disable iff (i_rst)
        (fire_alu && insn_r.op == OP_ORL) |=> acc_r == ($past(acc_r) | $past(insn_r.operand[7:0]));
    endproperty
    a_or_lit: assert property (p_or_lit)
        else $error("Literal OR gave a wrong accumulator.");

    property p_inc;
        @(posedge i_clk_sys) disable iff (i_rst)
        (fire_alu && insn_r.op == OP_INC) |=> dst_val == 8'($past(fval) + 8'h01);
    endproperty
    a_inc: assert property (p_inc)
        else $error("Increment gave a wrong result.");

    property p_dest_file;
        @(posedge i_clk_sys) disable iff (i_rst)
        (fire_alu && insn_r.dest && insn_r.op != OP_ORL) |=> $stable(acc_r);
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("File destination disturbed the accumulator.");

    property p_or_reg;
        @(posedge i_clk_sys) disable iff (i_rst)
        (fire_alu && insn_r.op == OP_ORF) |=> dst_val == ($past(acc_r) | $past(fval));
    endproperty
    a_or_reg: assert property (p_or_reg)
        else $error("Register OR gave a wrong result.");

    property p_shl;
        @(posedge i_clk_sys) disable iff (i_rst)
        (fire_alu && insn_r.op == OP_SHL) |=> dst_val == {$past(fval[6:0]), 1'b0}
            && c_r == $past(fval[7]);
    endproperty
    a_shl: assert property (p_shl)
        else $error("Left shift gave a wrong result or carry.");

    property p_shr;
        @(posedge i_clk_sys) disable iff (i_rst)
        (fire_alu && insn_r.op == OP_SHR) |=> dst_val == {1'b0, $past(fval[7:1])}
            && c_r == $past(fval[0]);
    endproperty
    a_shr: assert property (p_shr)
        else $error("Right shift gave a wrong result or carry.");

    property p_zero;
        @(posedge i_clk_sys) disable iff (i_rst)
        fire_alu |=> z_r == (dst_val == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("Zero flag does not match the result.");

    property p_alu_time;
        @(posedge i_clk_sys) disable iff (i_rst)
        (issue && i_pwdata[14:12] != OP_JUMP) |-> ##10 busy ##1 !busy;
    endproperty
    a_alu_time: assert property (p_alu_time)
        else $error("Single-cycle instruction did not finish in one cycle.");

endmodule : cbx_core

// ===== verilog/cbx_pkg.sv
// Contract
// - Jump loads 11-bit literal into counter bits 10:0
// - Jump fills counter bits 14:11 from latch
// - Jump takes two cycles, flags unchanged
// - OR literal into accumulator, update zero
// - Increment addressed register, write destination, update zero
// - Destination bit zero accumulator, one file register, except OR literal always to accumulator
// - OR accumulator with register, update zero
// - Left shift through carry, zero in
// - Right shift through carry, zero in
package cbx_pkg;

    // ==================================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned INSN_CYCLE_NS = 200;
    localparam int unsigned CYC_CLKS      = INSN_CYCLE_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  CYC_LAST      = 4'(CYC_CLKS - 1);

    // ==================================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_ISSUE  = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ACC    = 8'h08;
    localparam logic [7:0] ADDR_PC     = 8'h0C;
    localparam logic [7:0] ADDR_LATCH  = 8'h10;
    localparam logic [7:0] ADDR_FADDR  = 8'h14;
    localparam logic [7:0] ADDR_FDATA  = 8'h18;

    // ==================================================================
    // Field positions
    localparam int unsigned ISSUE_OPND_LSB = 0;
    localparam int unsigned ISSUE_DEST_BIT = 11;
    localparam int unsigned ISSUE_OP_LSB   = 12;
    localparam int unsigned STAT_BUSY_BIT  = 0;
    localparam int unsigned STAT_ZERO_BIT  = 1;
    localparam int unsigned STAT_CARRY_BIT = 2;
    localparam int unsigned JMP_LATCH_HI   = 6;
    localparam int unsigned JMP_LATCH_LO   = 3;

    // ==================================================================
    // Reset values
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [14:0] PC_RST    = 15'h0000;
    localparam logic [6:0]  LATCH_RST = 7'h00;
    localparam logic [6:0]  FADDR_RST = 7'h00;
    localparam logic [7:0]  FILE_RST  = 8'h00;
    localparam logic        FLAG_RST  = 1'b0;

    // ==================================================================
    // Types
    typedef enum logic [2:0] {
        OP_JUMP = 3'h0,
        OP_ORL  = 3'h1,
        OP_ORF  = 3'h2,
        OP_INC  = 3'h3,
        OP_SHL  = 3'h4,
        OP_SHR  = 3'h5
    } cbx_op_e;

    localparam logic [2:0] OP_LAST = 3'h5;

    typedef struct packed {
        cbx_op_e     op;
        logic        dest;
        logic [10:0] operand;
    } cbx_insn_s;

    typedef struct packed {
        logic [7:0] value;
        logic       zero;
        logic       carry;
        logic       carry_upd;
        logic       to_file;
    } cbx_alu_s;

endpackage : cbx_pkg
